// >>> core/vcs_defines.svh
// Constants for the camera sensor control and video port block.
// Assumes inclusion by bare name from the core folder.
`ifndef VCS_DEFINES_SVH
`define VCS_DEFINES_SVH

// Serial control bus slave addresses
`define VCS_ADDR_WR 8'h42
`define VCS_ADDR_RD 8'h43
`define VCS_BYTE_BITS 4'h8

// Register sub-addresses
`define VCS_REG_GAIN 8'h00
`define VCS_REG_IDH 8'h0a
`define VCS_REG_IDL 8'h0b
`define VCS_REG_VOPT 8'h0c
`define VCS_REG_OUTC 8'h0e
`define VCS_REG_COMC 8'h12

// Reset values
`define VCS_GAIN_RST 8'h00
`define VCS_VOPT_RST 8'h00
`define VCS_OUTC_RST 8'h00
`define VCS_COMC_RST 8'h11

// Field positions
`define VCS_COMC_SWRST 7
`define VCS_OUTC_SLEEP 3
`define VCS_OUTC_RANGE 2
`define VCS_VOPT_BAR 0

// Limited output range and scaled frame sizes
`define VCS_RANGE_LO 8'h10
`define VCS_RANGE_HI 8'hf0
`define VCS_CIF_W 11'h160
`define VCS_CIF_H 10'h120
`define VCS_QVGA_W 11'h140
`define VCS_QVGA_H 10'h0f0

`endif

// >>> core/vcs_pkg.sv
// Types shared by the camera sensor control and video port block.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package vcs_pkg;
    // Serial control slave states
    typedef enum logic [3:0] {
        VCS_IDLE, VCS_ADDR, VCS_ACK_AW, VCS_SUB, VCS_ACK_W, VCS_WR,
        VCS_ACK_RD, VCS_RD, VCS_MACK
    } vcs_ctl_state_t;
    // Output frame size selection
    typedef enum logic [1:0] {VCS_SCALE_VGA, VCS_SCALE_CIF, VCS_SCALE_QVGA} vcs_scale_t;
endpackage
`default_nettype wire

// >>> core/vcs_sensor.sv
// Camera sensor digital core: serial control slave, registers and video port.
// Assumes clk is the system clock and pix_clk the pixel-domain clock, unrelated.
//
// Overview of operation
// - Power-down pin high stops video, low runs
// - Hard reset low returns registers to defaults
// - Answer bus addresses 42 write, 43 read
// - Enable bits: one enables, zero disables
// - Gain register multiplies pixel values, 1x-31x
// - Eight-bit data bus, top bit most significant
// - Single shared ten-bit converter at pixel rate
// - Reduce ten-bit pixels to eight bits
// - Test pattern: colour bars or bit shift
// - Scaler shrinks frames to CIF or QVGA
// - Array 656x492, active region 640x480
// - Control register bits 1..0 set drive strength
// - Generate frame sync, line valid, pixel clock
// - Standby by bus command or power-down pin
// - Full frames at up to thirty per second
// - Data and line valid change on falling edge
// - Common control bit 7 soft-resets all registers
// - Drive codes 00..11 mean 1x..4x
`include "vcs_defines.svh"
`default_nettype none
module vcs_sensor #(
    parameter int H_TOTAL = 656,
    parameter int V_TOTAL = 492,
    parameter int H_ACTIVE = 640,
    parameter int V_ACTIVE = 480,
    parameter int VS_LINES = 4,
    parameter logic [7:0] ID_HIGH = 8'h5a, // Arbitrary identity value
    parameter logic [7:0] ID_LOW = 8'ha5 // Arbitrary identity value
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic pix_clk,
    input wire logic hard_reset_n,
    input wire logic power_down_in,
    input wire logic serial_ctrl_clock,
    input wire logic serial_ctrl_data_in,
    output logic serial_ctrl_data_out,
    output logic serial_ctrl_data_oe,
    input wire logic [1:0] scale_sel,
    input wire logic shift_pattern_en,
    input wire logic [9:0] adc_data,
    output logic pclk_out,
    output logic frame_sync_out,
    output logic line_valid_out,
    output logic [7:0] pix_data_out,
    output logic [1:0] drive_strength,
    output logic standby_out
);
    localparam int CFG_W = 13;
    localparam int CW = $clog2(H_TOTAL);
    localparam int RW = $clog2(V_TOTAL);

    // Pin synchronisers in the system domain
    logic hrst_s1, hrst_s2, pdn_s1, pdn_s2, scl_s1, scl_s2, sda_s1, sda_s2, scl_q, sda_q;
    logic ack_s1, ack_s2;
    logic ack_p;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            {hrst_s1, hrst_s2, scl_s1, scl_s2, scl_q, sda_s1, sda_s2, sda_q} <= 8'hff;
            {pdn_s1, pdn_s2, ack_s1, ack_s2} <= 4'h0;
        end else begin
            hrst_s1 <= hard_reset_n;
            hrst_s2 <= hrst_s1;
            pdn_s1 <= power_down_in;
            pdn_s2 <= pdn_s1;
            scl_s1 <= serial_ctrl_clock;
            scl_s2 <= scl_s1;
            scl_q <= scl_s2;
            sda_s1 <= serial_ctrl_data_in;
            sda_s2 <= sda_s1;
            sda_q <= sda_s2;
            ack_s1 <= ack_p;
            ack_s2 <= ack_s1;
        end
    end

    logic rst_any, start_ev, stop_ev, scl_rise, scl_fall;
    assign rst_any = sys_rst | ~hrst_s2;
    assign start_ev = scl_s2 & scl_q & sda_q & ~sda_s2;
    assign stop_ev = scl_s2 & scl_q & ~sda_q & sda_s2;
    assign scl_rise = scl_s2 & ~scl_q;
    assign scl_fall = ~scl_s2 & scl_q;

    // Serial control slave and register file state
    vcs_pkg::vcs_ctl_state_t st_reg, st_next;
    logic [3:0] cnt_reg, cnt_next;
    logic [7:0] sh_reg, sh_next, sub_reg, sub_next, rdata;
    logic oe_reg, oe_next, wr_en;
    logic [7:0] gain_reg, gain_next, vopt_reg, vopt_next, outc_reg, outc_next;
    logic [7:0] comc_reg, comc_next;
    logic stby_reg, stby_next;

    // Read data for the current sub-address; unmapped locations read zero
    always_comb begin
        unique case (sub_reg)
            `VCS_REG_GAIN: rdata = gain_reg;
            `VCS_REG_IDH: rdata = ID_HIGH;
            `VCS_REG_IDL: rdata = ID_LOW;
            `VCS_REG_VOPT: rdata = vopt_reg;
            `VCS_REG_OUTC: rdata = outc_reg;
            `VCS_REG_COMC: rdata = comc_reg;
            default: rdata = 8'h00;
        endcase
    end

    // Byte-level protocol: address, sub-address, then data bytes
    always_comb begin
        st_next = st_reg;
        cnt_next = cnt_reg;
        sh_next = sh_reg;
        sub_next = sub_reg;
        oe_next = oe_reg;
        wr_en = 1'b0;
        if (start_ev) begin
            st_next = vcs_pkg::VCS_ADDR;
            cnt_next = 4'h0;
            oe_next = 1'b0;
        end else if (stop_ev) begin
            st_next = vcs_pkg::VCS_IDLE;
            oe_next = 1'b0;
        end else if (scl_rise) begin
            unique case (st_reg)
                vcs_pkg::VCS_ADDR, vcs_pkg::VCS_SUB, vcs_pkg::VCS_WR: begin
                    if (cnt_reg < `VCS_BYTE_BITS) begin
                        sh_next = {sh_reg[6:0], sda_s2};
                        cnt_next = cnt_reg + 4'h1;
                    end
                end
                vcs_pkg::VCS_MACK: begin
                    // Master acknowledge asks for the next byte, a NACK ends the read
                    st_next = sda_s2 ? vcs_pkg::VCS_IDLE : vcs_pkg::VCS_ACK_RD;
                    sub_next = sub_reg + 8'h01;
                end
                default: ;
            endcase
        end else if (scl_fall) begin
            unique case (st_reg)
                vcs_pkg::VCS_ADDR: begin
                    if (cnt_reg == `VCS_BYTE_BITS) begin
                        if (sh_reg == `VCS_ADDR_WR) begin
                            st_next = vcs_pkg::VCS_ACK_AW;
                            oe_next = 1'b1;
                        end else if (sh_reg == `VCS_ADDR_RD) begin
                            st_next = vcs_pkg::VCS_ACK_RD;
                            oe_next = 1'b1;
                        end else begin
                            st_next = vcs_pkg::VCS_IDLE;
                        end
                    end
                end
                vcs_pkg::VCS_SUB: begin
                    if (cnt_reg == `VCS_BYTE_BITS) begin
                        sub_next = sh_reg;
                        oe_next = 1'b1;
                        st_next = vcs_pkg::VCS_ACK_W;
                    end
                end
                vcs_pkg::VCS_WR: begin
                    if (cnt_reg == `VCS_BYTE_BITS) begin
                        wr_en = 1'b1;
                        sub_next = sub_reg + 8'h01;
                        oe_next = 1'b1;
                        st_next = vcs_pkg::VCS_ACK_W;
                    end
                end
                vcs_pkg::VCS_ACK_AW, vcs_pkg::VCS_ACK_W: begin
                    oe_next = 1'b0;
                    cnt_next = 4'h0;
                    st_next = (st_reg == vcs_pkg::VCS_ACK_AW) ? vcs_pkg::VCS_SUB : vcs_pkg::VCS_WR;
                end
                vcs_pkg::VCS_ACK_RD: begin
                    // The acknowledge slot ends on this fall and bit 7 goes out at once
                    sh_next = rdata;
                    oe_next = ~rdata[7];
                    cnt_next = 4'h1;
                    st_next = vcs_pkg::VCS_RD;
                end
                vcs_pkg::VCS_RD: begin
                    if (cnt_reg == `VCS_BYTE_BITS) begin
                        oe_next = 1'b0;
                        st_next = vcs_pkg::VCS_MACK;
                    end else begin
                        oe_next = ~sh_reg[6];
                        sh_next = {sh_reg[6:0], 1'b0};
                        cnt_next = cnt_reg + 4'h1;
                    end
                end
                default: ;
            endcase
        end
    end

    // Register writes; a set reset bit reloads every default and is not stored
    always_comb begin
        gain_next = gain_reg;
        vopt_next = vopt_reg;
        outc_next = outc_reg;
        comc_next = comc_reg;
        if (wr_en) begin
            unique case (sub_reg)
                `VCS_REG_GAIN: gain_next = sh_reg;
                `VCS_REG_VOPT: vopt_next = sh_reg;
                `VCS_REG_OUTC: outc_next = sh_reg;
                `VCS_REG_COMC: begin
                    if (sh_reg[`VCS_COMC_SWRST]) begin
                        gain_next = `VCS_GAIN_RST;
                        vopt_next = `VCS_VOPT_RST;
                        outc_next = `VCS_OUTC_RST;
                        comc_next = `VCS_COMC_RST;
                    end else begin
                        comc_next = sh_reg;
                    end
                end
                default: ;
            endcase
        end
        stby_next = pdn_s2 | outc_next[`VCS_OUTC_SLEEP];
    end

    // Configuration handed to the pixel domain by a toggle handshake
    logic [CFG_W-1:0] cfg_live, hold_reg, hold_next;
    logic req_reg, req_next;
    assign cfg_live = {gain_reg, vopt_reg[`VCS_VOPT_BAR], outc_reg[`VCS_OUTC_RANGE],
                       scale_sel, shift_pattern_en};
    always_comb begin
        hold_next = hold_reg;
        req_next = req_reg;
        // Hold is frozen until the pixel side has echoed the toggle back
        if (req_reg == ack_s2 && cfg_live != hold_reg) begin
            hold_next = cfg_live;
            req_next = ~req_reg;
        end
    end

    always_ff @(posedge clk) begin
        if (rst_any) begin
            st_reg <= vcs_pkg::VCS_IDLE;
            {cnt_reg, sh_reg, sub_reg, oe_reg, req_reg} <= 22'h0;
            gain_reg <= `VCS_GAIN_RST;
            vopt_reg <= `VCS_VOPT_RST;
            outc_reg <= `VCS_OUTC_RST;
            comc_reg <= `VCS_COMC_RST;
            stby_reg <= 1'b0;
            hold_reg <= {CFG_W{1'b0}};
        end else begin
            st_reg <= st_next;
            cnt_reg <= cnt_next;
            sh_reg <= sh_next;
            sub_reg <= sub_next;
            oe_reg <= oe_next;
            gain_reg <= gain_next;
            vopt_reg <= vopt_next;
            outc_reg <= outc_next;
            comc_reg <= comc_next;
            stby_reg <= stby_next;
            hold_reg <= hold_next;
            req_reg <= req_next;
        end
    end
    assign serial_ctrl_data_out = 1'b0; // Open drain: only ever pulls low
    assign serial_ctrl_data_oe = oe_reg;
    assign drive_strength = outc_reg[1:0];
    assign standby_out = stby_reg;

    // Pixel-domain reset, standby and handshake synchronisers
    logic prst_1, prst_2, pst_1, pst_2, preq_1, preq_2, preq_3;
    always_ff @(posedge pix_clk) begin
        prst_1 <= rst_any;
        prst_2 <= prst_1;
        pst_1 <= stby_reg;
        pst_2 <= pst_1;
        preq_1 <= req_reg;
        preq_2 <= preq_1;
        preq_3 <= prst_2 ? 1'b0 : preq_2;
    end
    assign ack_p = preq_3;

    // Video timing and pixel pipeline state
    logic [CFG_W-1:0] cfg_reg, cfg_next;
    logic pclk_reg, pclk_next, fs_reg, fs_next, lv_reg, lv_next;
    logic [7:0] dat_reg, dat_next;
    logic [CW-1:0] col_reg, col_next;
    logic [RW-1:0] row_reg, row_next;
    logic [10:0] hacc_reg, hacc_next, out_w, hsum;
    logic [9:0] vacc_reg, vacc_next, out_h, vsum;
    logic [14:0] g_frac;
    logic [18:0] g_sh;
    logic [2:0] g_pop, bar;
    logic [9:0] g_val;
    logic [7:0] pix8;
    logic h_act, v_act, keep_h, keep_v;

    // Analog gain: (b7+1)(b6+1)(b5+1)(b4+1)(1+b[3:0]/16), saturating
    always_comb begin
        g_frac = 15'(adc_data) * 15'({1'b1, cfg_reg[8:5]});
        g_pop = 3'(cfg_reg[12]) + 3'(cfg_reg[11]) + 3'(cfg_reg[10]) + 3'(cfg_reg[9]);
        g_sh = 19'(g_frac) << g_pop;
        g_val = (|g_sh[18:14]) ? 10'h3ff : g_sh[13:4];
        bar = 3'(32'(col_reg) / (H_ACTIVE / 8));
        // Colour bars win over the bit-shift pattern when both are enabled
        if (cfg_reg[4]) pix8 = ~{bar, 5'h00};
        else if (cfg_reg[0]) pix8 = 8'h01 << col_reg[2:0];
        else pix8 = g_val[9:2];
        if (cfg_reg[3]) begin
            if (pix8 < `VCS_RANGE_LO) pix8 = `VCS_RANGE_LO;
            else if (pix8 > `VCS_RANGE_HI) pix8 = `VCS_RANGE_HI;
        end
    end

    // Scaler keeps pixels and lines by error accumulation
    always_comb begin
        unique case (cfg_reg[2:1])
            vcs_pkg::VCS_SCALE_CIF: begin out_w = `VCS_CIF_W; out_h = `VCS_CIF_H; end
            vcs_pkg::VCS_SCALE_QVGA: begin out_w = `VCS_QVGA_W; out_h = `VCS_QVGA_H; end
            default: begin out_w = 11'(H_ACTIVE); out_h = 10'(V_ACTIVE); end
        endcase
        h_act = 32'(col_reg) < H_ACTIVE;
        v_act = 32'(row_reg) >= V_TOTAL - V_ACTIVE;
        hsum = hacc_reg + out_w;
        vsum = vacc_reg + out_h;
        keep_h = hsum >= 11'(H_ACTIVE);
        keep_v = vsum >= 10'(V_ACTIVE);
    end

    // Outside standby, frame sync, line valid and data change only on the step where the pixel clock falls
    always_comb begin
        cfg_next = (preq_2 != preq_3) ? hold_reg : cfg_reg;
        pclk_next = ~pclk_reg;
        {fs_next, lv_next, dat_next} = {fs_reg, lv_reg, dat_reg};
        {col_next, row_next, hacc_next, vacc_next} = {col_reg, row_reg, hacc_reg, vacc_reg};
        if (pst_2) begin
            pclk_next = 1'b0;
            {fs_next, lv_next, dat_next} = 10'h000;
            {col_next, row_next, hacc_next, vacc_next} = '0;
        end else if (pclk_reg) begin
            fs_next = 32'(row_reg) < VS_LINES;
            lv_next = h_act & v_act & keep_h & keep_v;
            dat_next = lv_next ? pix8 : 8'h00;
            if (h_act) hacc_next = keep_h ? hsum - 11'(H_ACTIVE) : hsum;
            if (32'(col_reg) == H_TOTAL - 1) begin
                col_next = '0;
                hacc_next = 11'h000;
                if (v_act) vacc_next = keep_v ? vsum - 10'(V_ACTIVE) : vsum;
                if (32'(row_reg) == V_TOTAL - 1) begin
                    row_next = '0;
                    vacc_next = 10'h000;
                end else begin
                    row_next = row_reg + RW'(1);
                end
            end else begin
                col_next = col_reg + CW'(1);
            end
        end
    end

    always_ff @(posedge pix_clk) begin
        if (prst_2) begin
            cfg_reg <= {CFG_W{1'b0}};
            {pclk_reg, fs_reg, lv_reg, dat_reg} <= 11'h000;
            {col_reg, row_reg, hacc_reg, vacc_reg} <= '0;
        end else begin
            cfg_reg <= cfg_next;
            {pclk_reg, fs_reg, lv_reg, dat_reg} <= {pclk_next, fs_next, lv_next, dat_next};
            {col_reg, row_reg, hacc_reg, vacc_reg} <= {col_next, row_next, hacc_next, vacc_next};
        end
    end
    assign pclk_out = pclk_reg;
    assign frame_sync_out = fs_reg;
    assign line_valid_out = lv_reg;
    assign pix_data_out = dat_reg;

    // Pixels per line seen by the host, for the width checks
    logic [10:0] px_cnt;
    always_ff @(posedge pix_clk) begin
        if (prst_2 || !lv_reg) px_cnt <= 11'h000;
        else if (!pclk_reg) px_cnt <= px_cnt + 11'h001;
    end

    property p_edge;
        // Standby clears the outputs at once, whatever the pixel clock phase
        @(posedge pix_clk) disable iff (prst_2)
            !$past(pst_2) && ($changed(dat_reg) || $changed(lv_reg)) |-> $fell(pclk_reg);
    endproperty
    a_edge: assert property (p_edge) else $error("video outputs moved off a falling pixel clock");
    property p_width;
        @(posedge pix_clk) disable iff (prst_2) $fell(lv_reg) && !$past(pst_2) |-> px_cnt == out_w;
    endproperty
    a_width: assert property (p_width) else $error("line width differs from scaled size");
    property p_stby;
        @(posedge pix_clk) disable iff (prst_2) pst_2 |=> !pclk_reg && !lv_reg && dat_reg == 8'h00;
    endproperty
    a_stby: assert property (p_stby) else $error("video still running in standby");
    property p_range;
        @(posedge pix_clk) disable iff (prst_2)
            lv_reg && $stable(cfg_reg) && cfg_reg[3] |-> dat_reg >= `VCS_RANGE_LO && dat_reg <= `VCS_RANGE_HI;
    endproperty
    a_range: assert property (p_range) else $error("limited range data out of bounds");
    property p_unity;
        @(posedge pix_clk) disable iff (prst_2)
            pclk_reg && !pst_2 && lv_next && cfg_reg == {CFG_W{1'b0}} |=> dat_reg == $past(adc_data[9:2]);
    endproperty
    a_unity: assert property (p_unity) else $error("unity gain path does not pass top eight bits");
    property p_fsync;
        @(posedge pix_clk) disable iff (prst_2) $rose(lv_reg) |-> !fs_reg;
    endproperty
    a_fsync: assert property (p_fsync) else $error("line valid during frame sync");
    property p_badaddr;
        @(posedge clk) disable iff (rst_any)
            st_reg == vcs_pkg::VCS_ADDR && scl_fall && !start_ev && !stop_ev && cnt_reg == `VCS_BYTE_BITS
            && sh_reg != `VCS_ADDR_WR && sh_reg != `VCS_ADDR_RD |=> st_reg == vcs_pkg::VCS_IDLE && !oe_reg;
    endproperty
    a_badaddr: assert property (p_badaddr) else $error("foreign address acknowledged");
    property p_swrst;
        @(posedge clk) disable iff (rst_any) wr_en && sub_reg == `VCS_REG_COMC && sh_reg[`VCS_COMC_SWRST]
            |=> gain_reg == `VCS_GAIN_RST && outc_reg == `VCS_OUTC_RST && comc_reg == `VCS_COMC_RST;
    endproperty
    a_swrst: assert property (p_swrst) else $error("soft reset left a register changed");
    property p_hrst;
        @(posedge clk) !hrst_s2 |=> gain_reg == `VCS_GAIN_RST && vopt_reg == `VCS_VOPT_RST;
    endproperty
    a_hrst: assert property (p_hrst) else $error("hard reset left a register changed");
    property p_sleep;
        @(posedge clk) disable iff (rst_any) outc_reg[`VCS_OUTC_SLEEP] |-> stby_reg;
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep bit set without standby");
    c_read: cover property (@(posedge clk) disable iff (rst_any) st_reg == vcs_pkg::VCS_RD);
    c_write: cover property (@(posedge clk) disable iff (rst_any) wr_en);
    c_line: cover property (@(posedge pix_clk) disable iff (prst_2) $fell(lv_reg));
endmodule
`default_nettype wire

// >>> tb/vcs_host_model.sv
// Host-side partner: serial control bus master talking to the sensor.
// Assumes sda_in is the resolved open-drain data line with a pull-up.
`default_nettype none
module vcs_host_model (
    input wire logic clk,
    output logic scl,
    output logic sda_low,
    input wire logic sda_in
);
    timeunit 1ns;
    timeprecision 100ps;
    // Both lines start released; the pull-ups hold them high
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // Six clk per phase keeps every level well past the device's 2 FF sampling
    task automatic tick();
        repeat (6) @(posedge clk);
    endtask
    // Data changes only while the clock is low, sampled late in the high phase
    task automatic bit_io(input logic b, output logic r);
        sda_low <= !b;
        tick();
        scl <= 1'b1;
        tick();
        r = sda_in;
        scl <= 1'b0;
        tick();
    endtask
    // One byte MSB first; the acknowledge slot is always released by the host
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
        bit_io(1'b1, r);
        ack = !r;
    endtask
    task automatic start();
        sda_low <= 1'b1;
        tick();
        scl <= 1'b0;
        tick();
    endtask
    task automatic stop();
        sda_low <= 1'b1;
        tick();
        scl <= 1'b1;
        tick();
        sda_low <= 1'b0;
        tick();
    endtask
    // Address phase only, for refusal tests
    task automatic probe(input logic [7:0] addr, output logic ack);
        logic [7:0] rx;
        start();
        xfer(addr, rx, ack);
        stop();
    endtask
    task automatic write_reg(input logic [7:0] sub, input logic [7:0] d, output logic ok);
        logic [7:0] rx;
        logic a0, a1, a2;
        start();
        xfer(8'h42, rx, a0);
        xfer(sub, rx, a1);
        xfer(d, rx, a2);
        stop();
        ok = a0 & a1 & a2;
    endtask
    // Set the sub-address with a write, then read one byte and end with a NACK
    task automatic read_reg(input logic [7:0] sub, output logic [7:0] d, output logic ok);
        logic [7:0] rx;
        logic a0, a1, a2, a3;
        start();
        xfer(8'h42, rx, a0);
        xfer(sub, rx, a1);
        stop();
        start();
        xfer(8'h43, rx, a2);
        xfer(8'hff, d, a3);
        stop();
        ok = a0 & a1 & a2;
    endtask
endmodule
`default_nettype wire

// >>> tb/vcs_sensor_tb.sv
// Self-checking bench for the sensor core: registers, resets, standby, video.
// Assumes a shortened frame; pix_clk at 125 ns, unrelated to clk.
`default_nettype none
module vcs_sensor_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0, pix_clk = 1'b0, sys_rst = 1'b1, hard_reset_n = 1'b0, power_down_in = 1'b0;
    logic shift_pattern_en = 1'b0, ok;
    logic [1:0] scale_sel = 2'b00;
    logic [9:0] adc_data = 10'h000, adc_val = 10'h000;
    logic [7:0] rd, g;
    wire logic scl, sda_low, sda_in, sda_out, sda_oe, pclk_out, frame_sync_out, line_valid_out;
    wire logic standby_out;
    wire logic [7:0] pix_data_out;
    wire logic [1:0] drive_strength;
    int errors = 0, n_tests = 0, pclk_rises = 0;
    logic [7:0] subs [5] = '{8'h00, 8'h0c, 8'h0e, 8'h12, 8'h20};
    logic [7:0] vals [5] = '{8'h00, 8'h00, 8'h00, 8'h11, 8'h00};
    // Open-drain data line: low if either party pulls, else the pull-up wins
    assign sda_in = !(sda_low | (sda_oe & !sda_out));
    initial forever #5 clk = !clk;
    initial begin
        #17;
        forever #62.5 pix_clk = !pix_clk;
    end
    // Converter samples follow the pixel clock domain
    always @(posedge pix_clk) adc_data <= adc_val;
    always @(posedge pclk_out) pclk_rises++;
    vcs_sensor #(.H_TOTAL(20), .V_TOTAL(16), .H_ACTIVE(16), .V_ACTIVE(12), .VS_LINES(2))
        u_vcs_sensor (.clk(clk), .sys_rst(sys_rst), .pix_clk(pix_clk),
        .hard_reset_n(hard_reset_n), .power_down_in(power_down_in),
        .serial_ctrl_clock(scl), .serial_ctrl_data_in(sda_in),
        .serial_ctrl_data_out(sda_out), .serial_ctrl_data_oe(sda_oe), .scale_sel(scale_sel),
        .shift_pattern_en(shift_pattern_en), .adc_data(adc_data), .pclk_out(pclk_out),
        .frame_sync_out(frame_sync_out), .line_valid_out(line_valid_out),
        .pix_data_out(pix_data_out), .drive_strength(drive_strength), .standby_out(standby_out));
    vcs_host_model u_vcs_host_model (.clk(clk), .scl(scl), .sda_low(sda_low), .sda_in(sda_in));
    task automatic check(input logic good, input string msg);
        n_tests++;
        if (good !== 1'b1) begin
            errors++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask
    // Gain product on the 10-bit sample, saturated, then reduced to 8 bits
    function automatic logic [7:0] exp_pix(input logic [7:0] gv, input logic [9:0] a);
        int p;
        p = a * (gv[7] + 1) * (gv[6] + 1) * (gv[5] + 1) * (gv[4] + 1) * (16 + gv[3:0]) / 16;
        if (p > 1023) p = 1023;
        return p[9:2];
    endfunction
    // Mode 1 bit shift, 2 colour bars (two columns per bar here), 3 limited range
    function automatic logic [7:0] exp_at(input logic [1:0] mode, input logic [7:0] gv, input int n);
        logic [7:0] p;
        p = exp_pix(gv, adc_val);
        if (mode == 2'd1) return 8'h01 << n[2:0];
        if (mode == 2'd2) return ~{3'(n / 2), 5'h00};
        if (mode == 2'd3 && p < 8'h10) return 8'h10;
        if (mode == 2'd3 && p > 8'hf0) return 8'hf0;
        return p;
    endfunction
    // Waits for a fresh frame so new settings are in force, then checks one line
    task automatic check_line(input logic [1:0] mode, input logic [7:0] gv);
        int n, t;
        n = 0;
        t = 0;
        while (frame_sync_out !== 1'b0 && t < 3000) begin @(posedge pix_clk); t++; end
        while (frame_sync_out !== 1'b1 && t < 3000) begin @(posedge pix_clk); t++; end
        while (line_valid_out !== 1'b1 && t < 3000) begin @(posedge pclk_out); t++; end
        // Host samples on the rising pixel clock, away from the falling-edge updates
        while (line_valid_out === 1'b1) begin
            check(pix_data_out === exp_at(mode, gv, n), "pixel");
            n++;
            @(posedge pclk_out);
        end
        check(n == 16, "pixels per line");
        @(posedge clk);
    endtask
    task automatic standby_check(input logic exp_on);
        int r0;
        repeat (20) @(posedge pix_clk);
        r0 = pclk_rises;
        repeat (20) @(posedge pix_clk);
        check(standby_out === exp_on, "standby level");
        check((pclk_rises == r0) == exp_on, "pixel clock in standby");
        @(posedge clk);
    endtask
    task automatic conclude();
        $display("errors=%0d n_tests=%0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (90000) @(posedge clk);
        errors++;
        $display("[FAIL] %0t watchdog expired", $time);
        conclude();
    end
    initial begin
        void'($urandom(32'h40b8));
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        // Hard reset held longer so the pixel domain sees several edges
        repeat (40) @(posedge clk);
        hard_reset_n <= 1'b1;
        repeat (30) @(posedge clk);
        for (int i = 0; i < 5; i++) begin
            u_vcs_host_model.read_reg(subs[i], rd, ok);
            check(ok === 1'b1 && rd === vals[i], "default value");
        end
        u_vcs_host_model.probe(8'h44, ok);
        check(ok === 1'b0, "foreign address acked");
        for (int i = 0; i < 4; i++) begin
            u_vcs_host_model.write_reg(8'h0e, 8'(i), ok);
            check(ok === 1'b1 && drive_strength === 2'(i), "drive strength pins");
            u_vcs_host_model.read_reg(8'h0e, rd, ok);
            check(rd === 8'(i), "drive strength readback");
        end
        u_vcs_host_model.write_reg(8'h12, 8'h80, ok);
        u_vcs_host_model.read_reg(8'h0e, rd, ok);
        check(rd === 8'h00, "soft reset clears control");
        u_vcs_host_model.read_reg(8'h12, rd, ok);
        check(rd === 8'h11, "soft reset common value");
        shift_pattern_en <= 1'b1;
        check_line(2'd1, 8'h00);
        shift_pattern_en <= 1'b0;
        // Select code 11 falls back to the full frame
        scale_sel <= 2'b11;
        g = 8'($urandom);
        adc_val <= 10'($urandom);
        u_vcs_host_model.write_reg(8'h00, g, ok);
        u_vcs_host_model.read_reg(8'h00, rd, ok);
        check(rd === g, "gain readback");
        check_line(2'd0, g);
        scale_sel <= 2'b00;
        // Long enough for the pixel domain to see the reset too
        hard_reset_n <= 1'b0;
        repeat (40) @(posedge clk);
        hard_reset_n <= 1'b1;
        adc_val <= 10'h3ff;
        repeat (30) @(posedge clk);
        u_vcs_host_model.read_reg(8'h00, rd, ok);
        check(rd === 8'h00, "hard reset clears gain");
        check_line(2'd0, 8'h00);
        u_vcs_host_model.write_reg(8'h0c, 8'h01, ok);
        check_line(2'd2, 8'h00);
        u_vcs_host_model.write_reg(8'h0c, 8'h00, ok);
        u_vcs_host_model.write_reg(8'h0e, 8'h04, ok);
        check_line(2'd3, 8'h00);
        u_vcs_host_model.write_reg(8'h0e, 8'h08, ok);
        standby_check(1'b1);
        u_vcs_host_model.write_reg(8'h0e, 8'h00, ok);
        power_down_in <= 1'b1;
        standby_check(1'b1);
        power_down_in <= 1'b0;
        standby_check(1'b0);
        conclude();
    end
endmodule
`default_nettype wire
